// *** pam_an_model.sv ***
// Autoneg engine stand-in for the bench
`timescale 1ns/1ps
module pam_an_model (
   input wire logic clk, // Clock
   input wire logic rst_n, // Reset
   input wire logic [18:0] req, // Sent, done, page, word
   output logic [18:0] ev // Pulses in the same layout
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) ev <= 19'h0;
      else ev <= {req[18:16], req[16] ? req[15:0] : ~ev[15:0]}; // Word churns off its pulse
   end
endmodule : pam_an_model

// *** pam_pkg.sv ***
// Package with register map, field positions and reset values for the autoneg management bank
package pam_pkg;
   localparam logic [4:0] OFF_EXPANSION = 5'h06;
   localparam logic [4:0] OFF_NP_TX = 5'h07;
   localparam logic [4:0] OFF_NP_RX = 5'h08;
   localparam logic [4:0] OFF_EXT_STATUS = 5'h0F;
   localparam logic [4:0] OFF_AN_INT_CTRL = 5'h10;
   localparam logic [4:0] OFF_LOOP_POS = 5'h11;
   localparam logic [4:0] OFF_IRQ_STATUS = 5'h18;
   localparam logic [4:0] OFF_IRQ_MASK = 5'h19;
   localparam int EXP_NP_ABLE_BIT = 2;
   localparam int EXP_PAGE_RX_BIT = 1;
   localparam int NP_NEXT_BIT = 15;
   localparam int NP_ACK_BIT = 14;
   localparam int NP_MSG_BIT = 13;
   localparam int NP_ACK2_BIT = 12;
   localparam int NP_TOGGLE_BIT = 11;
   localparam int NP_CODE_MSB = 10;
   localparam int EXT_FD_X_BIT = 15;
   localparam int INT_STATUS_BIT = 1;
   localparam int INT_ENABLE_BIT = 0;
   localparam int LOOP_POS_BIT = 0;
   localparam logic [10:0] NP_CODE_RST = 11'h001;
   localparam logic NP_MSG_RST = 1'b1;
   localparam logic INT_ENABLE_RST = 1'b1;
   // Sticky event bits of the interrupt status register
   localparam int EV_PAGE_RX = 0;
   localparam int EV_AN_DONE = 1;
   localparam int EV_TX_TAKEN = 2;
   localparam int EV_W = 3;
   localparam logic [EV_W-1:0] IRQ_MASK_RST = 3'h0;
endpackage : pam_pkg

// *** pam_props.sv ***
// Port checker for the autoneg bank
`timescale 1ns/1ps
module pam_props (
   input wire logic clk, // Clock
   input wire logic rst_n, // Reset
   input wire logic clk_en, // Run
   input wire logic [4:0] addr, // Address
   input wire logic [15:0] wr_data, // Data in
   input wire logic wr_en, // Write
   input wire logic rd_en, // Read
   input wire logic [15:0] rd_data, // Data out
   input wire logic an_complete, // Done
   input wire logic an_int_status // Status
);
   wire rd_ok = rd_en && clk_en;
   wire ic_wr = wr_en && clk_en && addr == 5'h10;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   exp_fixed_a: assert property (rd_ok && addr == 5'h06
      |=> rd_data[15:2] == 14'h1 && !rd_data[0]) else $error("expansion");
   ext_fixed_a: assert property (rd_ok && addr == 5'h0F |=> rd_data == 16'h8000) else $error("ext");
   int_rsvd_a: assert property (rd_ok && addr == 5'h10 |=> rd_data[15:2] == 14'h0) else $error("ctrl");
   loop_rsvd_a: assert property (rd_ok && addr == 5'h11 |=> rd_data[15:1] == 15'h0) else $error("loop");
   stat_cause_a: assert property ($rose(an_int_status) |-> $past(an_complete)) else $error("stray");
   stat_hold_a: assert property (an_int_status && !ic_wr |=> an_int_status) else $error("lost");
   stat_clr_a: assert property (ic_wr && !wr_data[1] && !an_complete
      |=> !an_int_status) else $error("kept");
   stat_off_a: assert property (ic_wr && !wr_data[0] |=> !an_int_status) else $error("on");
endmodule : pam_props
bind pam_regs pam_props u_props (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .addr(addr), .wr_data(wr_data),
   .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .an_complete(an_complete), .an_int_status(an_int_status));

// *** pam_regs.sv ***
// Autoneg expansion, next page, extended status, interrupt and loopback position registers
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
// Overview of operation
// (RULE1) Expansion reads bit 2 as one, bit 0 and bits 3-15 as zero.
// (RULE2) Expansion bit 1 sets on new page, clears on read, resets zero.
// (RULE3) Next page transmit bit 15 read-write, resets zero, one means more pages.
// (RULE4) Transmit code bits 0-10 reset 0x001; bit 13 selects message, resets one.
// (RULE5) Transmit bit 12 comply flag read-write, resets zero.
// (RULE6) Bit 11 of both next page registers read-only, toggles per page.
// (RULE7) Next page receive read-only, resets zero, holds partner page fields.
// (RULE8) Extended status reads bit 15 one, all other bits zero.
// (RULE9) Interrupt status sets on completion while enabled, held until written zero.
// (RULE10) Interrupt enable bit 0 resets one; zero forces status zero.
// (RULE11) Loopback position bit 0 read-write, resets zero, selects loopback point.
// (RULE12) Writes to read-only, constant or reserved bits have no effect.
// (RULE13) Host clears completion status by writing zero after servicing.
module pam_regs (
   input wire logic clk, // 50 MHz clock
   input wire logic rst_n, // Async reset, active low
   input wire logic clk_en, // Freezes all state while low
   input wire logic [4:0] addr, // Register address
   input wire logic [15:0] wr_data, // Write data
   input wire logic wr_en, // Write strobe
   input wire logic rd_en, // Read strobe
   output logic [15:0] rd_data, // Read data, cycle after strobe
   input wire logic an_page_rx, // Pulse: page received from partner
   input wire logic [15:0] an_lp_page, // Partner next page, valid with pulse
   input wire logic an_complete, // Pulse: autoneg cycle done
   input wire logic an_tx_taken, // Pulse: transmit page sent
   output logic [15:0] np_tx_page, // Page offered to the engine
   output logic loop_inside, // Loopback position select
   output logic an_int_status, // Completion interrupt status bit
   output logic irq // Level interrupt
);
   typedef struct packed {
      logic [15:0] rd_data;
      logic page_rx;
      logic np_next;
      logic np_msg;
      logic np_ack2;
      logic np_toggle;
      logic [10:0] np_code;
      logic [15:0] np_rx;
      logic int_status;
      logic int_enable;
      logic loop_pos;
      logic [pam_pkg::EV_W-1:0] ev_status;
      logic [pam_pkg::EV_W-1:0] ev_mask;
      logic irq;
   } pam_state_s;

   pam_state_s r;
   pam_state_s next_r;

   function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
      hit = (a == off);
   endfunction : hit

   function automatic logic [15:0] np_tx_word(input pam_state_s s);
      logic [15:0] w;
      w = 16'h0000;
      w[pam_pkg::NP_NEXT_BIT] = s.np_next;
      w[pam_pkg::NP_MSG_BIT] = s.np_msg;
      w[pam_pkg::NP_ACK2_BIT] = s.np_ack2;
      w[pam_pkg::NP_TOGGLE_BIT] = s.np_toggle;
      w[pam_pkg::NP_CODE_MSB:0] = s.np_code;
      np_tx_word = w;
   endfunction : np_tx_word

   always_comb begin
      logic [15:0] rv;
      logic [pam_pkg::EV_W-1:0] ev;
      rv = 16'h0000; // RULE12
      ev = {an_tx_taken, an_complete, an_page_rx};
      next_r = r;
      // Read mux; unmapped addresses return zero
      if (hit(addr, pam_pkg::OFF_EXPANSION)) begin
         rv[pam_pkg::EXP_NP_ABLE_BIT] = 1'b1; // RULE1
         rv[pam_pkg::EXP_PAGE_RX_BIT] = r.page_rx; // RULE2
      end
      if (hit(addr, pam_pkg::OFF_NP_TX)) begin
         rv = np_tx_word(r);
      end
      if (hit(addr, pam_pkg::OFF_NP_RX)) begin
         rv = r.np_rx; // RULE7
      end
      if (hit(addr, pam_pkg::OFF_EXT_STATUS)) begin
         rv[pam_pkg::EXT_FD_X_BIT] = 1'b1; // RULE8
      end
      if (hit(addr, pam_pkg::OFF_AN_INT_CTRL)) begin
         rv[pam_pkg::INT_STATUS_BIT] = r.int_status; // RULE10
         rv[pam_pkg::INT_ENABLE_BIT] = r.int_enable;
      end
      if (hit(addr, pam_pkg::OFF_LOOP_POS)) begin
         rv[pam_pkg::LOOP_POS_BIT] = r.loop_pos; // RULE11
      end
      if (hit(addr, pam_pkg::OFF_IRQ_STATUS)) begin
         rv[pam_pkg::EV_W-1:0] = r.ev_status;
      end
      if (hit(addr, pam_pkg::OFF_IRQ_MASK)) begin
         rv[pam_pkg::EV_W-1:0] = r.ev_mask;
      end
      if (rd_en) begin
         next_r.rd_data = rv;
      end

      // Page received flag; new page wins over read clear
      if (rd_en && hit(addr, pam_pkg::OFF_EXPANSION)) begin
         next_r.page_rx = 1'b0; // RULE2
      end
      if (an_page_rx) begin
         next_r.page_rx = 1'b1; // RULE2
         next_r.np_rx = an_lp_page; // RULE7
      end

      // Only defined read-write fields take writes; bit 14 and toggle ignored
      if (wr_en && hit(addr, pam_pkg::OFF_NP_TX)) begin
         next_r.np_next = wr_data[pam_pkg::NP_NEXT_BIT]; // RULE3
         next_r.np_msg = wr_data[pam_pkg::NP_MSG_BIT]; // RULE4
         next_r.np_ack2 = wr_data[pam_pkg::NP_ACK2_BIT]; // RULE5
         next_r.np_code = wr_data[pam_pkg::NP_CODE_MSB:0]; // RULE4
      end
      // Toggle flips once each page leaves, so successive pages alternate
      if (an_tx_taken) begin
         next_r.np_toggle = ~r.np_toggle; // RULE6
      end

      if (wr_en && hit(addr, pam_pkg::OFF_AN_INT_CTRL)) begin
         next_r.int_enable = wr_data[pam_pkg::INT_ENABLE_BIT]; // RULE10
         // Writing one does not set; zero clears it, and so does writing enable zero
         if (!wr_data[pam_pkg::INT_STATUS_BIT]) begin
            next_r.int_status = 1'b0; // RULE9
         end
      end
      if (an_complete && r.int_enable) begin
         next_r.int_status = 1'b1; // RULE9
      end
      if (!next_r.int_enable) begin
         next_r.int_status = 1'b0; // RULE10
      end

      if (wr_en && hit(addr, pam_pkg::OFF_LOOP_POS)) begin
         next_r.loop_pos = wr_data[pam_pkg::LOOP_POS_BIT]; // RULE11
      end

      // Sticky events: read clears, a same-cycle event survives
      if (wr_en && hit(addr, pam_pkg::OFF_IRQ_MASK)) begin
         next_r.ev_mask = wr_data[pam_pkg::EV_W-1:0];
      end
      if (rd_en && hit(addr, pam_pkg::OFF_IRQ_STATUS)) begin
         next_r.ev_status = ev;
      end else begin
         next_r.ev_status = r.ev_status | ev;
      end
      next_r.irq = |(next_r.ev_status & next_r.ev_mask);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
         r.np_msg <= pam_pkg::NP_MSG_RST; // RULE4
         r.np_code <= pam_pkg::NP_CODE_RST; // RULE4
         r.int_enable <= pam_pkg::INT_ENABLE_RST; // RULE10
         r.ev_mask <= pam_pkg::IRQ_MASK_RST;
      end else if (clk_en) begin
         r <= next_r;
      end
   end

   // Outputs all come straight from state flip-flops
   assign rd_data = r.rd_data;
   assign np_tx_page = np_tx_word(r);
   assign loop_inside = r.loop_pos; // RULE11
   assign an_int_status = r.int_status;
   assign irq = r.irq;
endmodule : pam_regs

// *** tb_top.sv ***
// Bench for the autoneg bank
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; $display("BAD %0t got %h", $time, g); end end
module tb_top;
   logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, wr_en = 1'b0, rd_en = 1'b0, irq, loop_inside, an_int_status;
   logic [4:0] addr = 5'h00;
   logic [15:0] wr_data = 16'h0000, rd_data, np_tx_page;
   logic [18:0] req = 19'h0, ev;
   int fails = 0, check_count = 0;
   pam_an_model u_an (.clk(clk), .rst_n(rst_n), .req(req), .ev(ev));
   pam_regs dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rd_data), .an_page_rx(ev[16]), .an_lp_page(ev[15:0]), .an_complete(ev[17]),
      .an_tx_taken(ev[18]), .np_tx_page(np_tx_page), .loop_inside(loop_inside), .an_int_status(an_int_status),
      .irq(irq));
   initial forever #10 clk = ~clk;
   // Kind 0 reads, 1 writes, 2 fires engine events
   task automatic op(input int k, input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      {rd_en, wr_en, addr, wr_data} <= {k == 0, k == 1, a, d};
      req <= (k == 2) ? {a[2:0], d} : 19'h0;
      @(posedge clk);
      {rd_en, wr_en, req} <= 21'h0;
      if (k == 2) repeat (3) @(posedge clk);
      #1 if (k == 0) `CHK(rd_data, d)
   endtask : op
   task automatic stop_test;
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : stop_test
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      op(0, 5'h07, 16'h2001);
      op(0, 5'h0F, 16'h8000);
      op(0, 5'h1F, 16'h0000);
      op(1, 5'h07, 16'hFFFF);
      op(2, 5'h04, 16'h0000);
      op(0, 5'h07, 16'hBFFF);
      `CHK(np_tx_page, 16'hBFFF)
      op(2, 5'h01, 16'hDA55);
      op(1, 5'h06, 16'hFFFF);
      op(0, 5'h06, 16'h0006);
      op(0, 5'h06, 16'h0004);
      op(1, 5'h08, 16'h0000);
      op(0, 5'h08, 16'hDA55);
      op(1, 5'h19, 16'h0002);
      op(2, 5'h02, 16'h0000);
      `CHK(irq, 1'b1)
      `CHK(an_int_status, 1'b1)
      op(0, 5'h10, 16'h0003);
      op(1, 5'h10, 16'hFFFD);
      `CHK(an_int_status, 1'b0)
      op(0, 5'h10, 16'h0001);
      op(0, 5'h18, 16'h0007);
      op(0, 5'h18, 16'h0000);
      `CHK(irq, 1'b0)
      op(1, 5'h10, 16'h0000);
      // Completion while disabled must not set the status bit
      op(2, 5'h02, 16'h0000);
      `CHK(an_int_status, 1'b0)
      op(0, 5'h10, 16'h0000);
      op(1, 5'h11, 16'hFFFF);
      op(0, 5'h11, 16'h0001);
      `CHK(loop_inside, 1'b1)
      // Frozen clock enable: this write must be lost
      @(posedge clk);
      clk_en <= 1'b0;
      op(1, 5'h11, 16'h0000);
      @(posedge clk);
      clk_en <= 1'b1;
      op(0, 5'h11, 16'h0001);
      // Mid-run reset restores the reset values
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      op(0, 5'h10, 16'h0001);
      op(0, 5'h11, 16'h0000);
      `CHK(loop_inside, 1'b0)
      `CHK(np_tx_page, 16'h2001)
      `CHK(irq, 1'b0)
      stop_test;
   end
   initial begin
      repeat (2000) @(posedge clk);
      fails++;
      stop_test;
   end
endmodule : tb_top
